/* File: rtl/acc_pkg.sv */
/*
 Constants shared by the converter control block: register map, bit
 positions, reset values, channel codes and timing counts.
 Assumes a 50 MHz bus clock and a 32-bit Avalon-MM register slave.
*/
package acc_pkg;
    // Register byte addresses (word aligned)
    localparam logic [3:0] REG_SC1 = 4'h0; // Status and control one
    localparam logic [3:0] REG_SC2 = 4'h4; // Status and control two
    localparam logic [3:0] REG_CVAL = 4'h8; // Ten-bit compare value
    localparam logic [3:0] REG_RES = 4'hc; // Result low in 7:0, high in 9:8, read clears flag
    localparam logic [3:0] REG_MODE = 4'h0; // Unused alias guard
    // Control one fields
    localparam int SC1_CONVERSION_COMPLETE_FLAG = 7;
    localparam int SC1_COMPLETE_IRQ_ENABLE = 6;
    localparam int SC1_CONTINUOUS_ENABLE = 5;
    localparam int SC1_CH_HI = 4;
    // Control two fields
    localparam int SC2_ACT = 7;
    localparam int SC2_TRG = 6;
    localparam int SC2_CFE = 5;
    localparam int SC2_CGT = 4;
    localparam int SC2_MODE10 = 0;
    // Reset values
    localparam logic [4:0] CH_RESET = 5'h1f;
    localparam logic [7:0] SC2_RESET = 8'h00;
    localparam logic [9:0] CVAL_RESET = 10'h000;
    // Channel codes
    localparam logic [4:0] CH_LAST_INPUT = 5'h1b;
    localparam logic [4:0] CH_RESERVED = 5'h1c;
    localparam logic [4:0] CH_REF_HIGH = 5'h1d;
    localparam logic [4:0] CH_REF_LOW = 5'h1e;
    localparam logic [4:0] CH_OFF = 5'h1f;
    // Conversion timing
    localparam int CLK_HZ = 50_000_000;
    localparam int CONV_NS = 400;
    localparam int CONV_CYCLES = (CONV_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [4:0] CONV_LAST = 5'(CONV_CYCLES - 1);
    // Sequencer states
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } acc_state_type;
endpackage

/* File: rtl/acc_compare.sv */
/*
 Compare unit: decides whether a finished result meets the compare
 condition. Assumes result and compare value are stable when sampled.
*/
`timescale 1ns/1ns
`default_nettype none
module acc_compare (
    input wire logic [9:0] result,
    input wire logic [9:0] compare_value,
    input wire logic mode_ten_bit,
    input wire logic compare_greater_equal,
    output logic hit
);
    // Operands narrowed to eight bits in 8-bit mode
    wire [9:0] res_eff = mode_ten_bit ? result : {2'b00, result[7:0]};
    wire [9:0] cmp_eff = mode_ten_bit ? compare_value : {2'b00, compare_value[7:0]};
    wire below = res_eff < cmp_eff;
    // Direction select
    assign hit = compare_greater_equal ? !below : below;
endmodule
`default_nettype wire

/* File: rtl/acc_top.sv */
/*
 Conversion control for a successive-approximation converter: trigger
 selection, single and continuous sequencing, complete flag, active bit,
 compare gating and result capture, behind an Avalon-MM slave.
 Assumes the analogue core delivers a code on sar_code when sar_done
 pulses, and the tick counter pulses hw_trigger_in once per overflow.
*/
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module acc_top (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic hw_trigger_in,
    input wire logic [9:0] sar_code,
    input wire logic sar_done,
    output logic sar_start,
    output logic sar_power,
    output logic [4:0] sar_channel,
    output logic complete_irq
);
    // Operation notes for the next engineer
    // Two states only: idle, which is also the low-power state, and converting.
    // The analogue core is powered while converting, or in the start cycle.
    // A start pulse on sar_start always comes with sar_power high.
    // The core answers with sar_done and a code, once per start.
    // The cycle counter only watches a conversion, it never ends one.
    // Counter saturates at its last value, so a stalled core stays visible.
    //
    // Software trigger path
    // A control-one write with a live channel starts at once.
    // The start goes out in the same cycle as the bus answer.
    // A write during a conversion drops the running one first.
    // A sar_done in the write cycle is ignored, so it cannot set the flag.
    // A write with the channel off only aborts and powers down.
    //
    // Hardware trigger path
    // Rising edges of hw_trigger_in are found by one history flop.
    // A level held high counts as one trigger only.
    // Edges while converting are dropped, not queued.
    // A control-one write in this mode aborts and then waits for an edge.
    // An edge in the same cycle as that write is dropped as well.
    // With the channel off, edges are ignored entirely.
    //
    // Continuous operation
    // A start arms the run, a control-one write disarms it.
    // Start wins over disarm when both fall in one cycle.
    // While armed and continuous, each accepted or refused end restarts.
    // Writing the off code stops the run with no trailing conversion.
    //
    // Complete flag
    // Set on an accepted end, cleared by control-one write or result read.
    // Set wins when an end and a clear fall in one cycle.
    // Software cannot write the flag, only clear it by side effect.
    // The interrupt line is the flag gated by its enable.
    // Enabling the interrupt is a control-one write, which clears a set flag, so the line stays low.
    //
    // Compare gating
    // With compare off every end is accepted.
    // With compare on only a true compare is accepted.
    // A refused end leaves both the flag and the result untouched.
    // In 8-bit mode the two upper bits take no part in the compare.
    //
    // Result word
    // Low eight bits in 7:0, upper two in 9:8, read as one word.
    // In 8-bit mode the upper two bits are stored as zeros.
    // A single read of the word clears the complete flag.
    // No interlock between halves is needed with one word.
    //
    // Register bus
    // Every request sees exactly one wait state.
    // Read data is captured in the wait cycle and stands until the next read.
    // Writes land at the edge where waitrequest is low.
    // Control registers need byte lane zero; the compare value takes any write.
    // Unmapped reads return zero, unmapped writes are dropped.
    //
    // Reset
    // The external reset is asynchronous on assertion.
    // Release passes through two flops, so all state leaves reset together.
    // After reset the channel field reads as off and all else as zero.
    //
    // Hazards
    // hw_trigger_in is taken as synchronous; a foreign source needs a sync.
    // A trigger already high at reset release counts as an edge.
    // Changing compare settings mid-conversion affects that conversion.
    // Changing the mode bit mid-conversion affects how its result is stored.
    //
    // Limits
    // No result interlock, no sample-time control, no clock divider.
    // The core's own timing is outside this block.
    // One conversion in flight at a time.
    //
    // Signal naming
    // Registers end in _q, decode wires carry plain names.
    // The read mux is a function so the address map is kept in one place.
    //
    // Tag map
    // Bus decode carries the write and read strobes used by every rule.
    // The sequencer carries starts, aborts and the return to low power.
    // The flag process carries set and clear priority.
    // The compare unit carries direction and width selection.
    //
    // Test hooks
    // None: every internal event except the counter reaching its last value shows on a port or in a register.
    //
    // Reset release synchroniser
    logic rst_meta_q;
    logic rst_n_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // Register state
    logic [4:0] channel_select_q; // Channel field
    logic complete_irq_enable_q; // Interrupt enable
    logic continuous_enable_q; // Continuous mode
    logic conversion_complete_flag_q; // Sticky complete flag
    logic trigger_select_q; // Hardware trigger chosen
    logic compare_enable_q; // Compare on
    logic compare_greater_equal_q; // Compare direction
    logic mode_ten_bit_q; // Ten-bit result mode
    logic [9:0] compare_value_q; // Compare threshold
    logic [9:0] result_q; // Captured result
    logic [31:0] rdata_q; // Registered read data
    logic ack_q; // Answer phase flag
    logic trig_prev_q; // Trigger history for edges
    logic [4:0] cnt_q; // Conversion cycle counter
    logic armed_q; // Continuous run armed by trigger
    acc_pkg::acc_state_type state_q;

    // Bus decode: one wait state, answer on the second cycle
    wire req = avs_read | avs_write;
    wire take = req & ack_q;
    assign avs_waitrequest = req & !ack_q;
    wire wr_sc1 = take & avs_write & avs_byteenable[0] & (avs_address == acc_pkg::REG_SC1);
    wire wr_sc2 = take & avs_write & avs_byteenable[0] & (avs_address == acc_pkg::REG_SC2);
    wire wr_cval = take & avs_write & (avs_address == acc_pkg::REG_CVAL);
    wire rd_res = take & avs_read & (avs_address == acc_pkg::REG_RES);
    wire [4:0] wr_channel = avs_writedata[acc_pkg::SC1_CH_HI:0];
    wire wr_ch_off = (wr_channel == acc_pkg::CH_OFF);

    // Trigger sources
    wire hw_edge = hw_trigger_in & !trig_prev_q;
    // Software start: write with software trigger and live channel
    wire sw_go = wr_sc1 & !wr_ch_off & !trigger_select_q;
    // Hardware start, ignored while channel is off
    wire hw_go = hw_edge & trigger_select_q & (channel_select_q != acc_pkg::CH_OFF)
        & !wr_sc1;
    // Hardware arm after a control-one write in hardware mode awaits an edge
    wire start_now = sw_go | hw_go;

    // Conversion completion and compare
    wire conv_end = (state_q == acc_pkg::ST_CONV) & sar_done & !wr_sc1;
    wire cmp_hit;
    acc_compare u_cmp (
        .result(sar_code),
        .compare_value(compare_value_q),
        .mode_ten_bit(mode_ten_bit_q),
        .compare_greater_equal(compare_greater_equal_q),
        .hit(cmp_hit)
    );
    wire accept = conv_end & (!compare_enable_q | cmp_hit);
    // Continuous: restart in the same cycle as the end
    wire restart = conv_end & continuous_enable_q & armed_q;
    wire timeout = (state_q == acc_pkg::ST_CONV) & (cnt_q == acc_pkg::CONV_LAST) & !sar_done;

    // Bus answer phase
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & !ack_q;
        end
    end

    // Read data mux, reserved bits zero
    function automatic logic [31:0] read_mux(input logic [3:0] a, input logic [7:0] s1,
        input logic [7:0] s2, input logic [9:0] cv, input logic [9:0] rs);
        case (a)
            acc_pkg::REG_SC1: read_mux = {24'h000000, s1};
            acc_pkg::REG_SC2: read_mux = {24'h000000, s2};
            acc_pkg::REG_CVAL: read_mux = {22'h0, cv};
            acc_pkg::REG_RES: read_mux = {22'h0, rs};
            default: read_mux = 32'h00000000;
        endcase
    endfunction
    wire [7:0] sc1_view = {conversion_complete_flag_q, complete_irq_enable_q,
        continuous_enable_q, channel_select_q};
    wire [7:0] sc2_view = {(state_q == acc_pkg::ST_CONV), trigger_select_q, compare_enable_q,
        compare_greater_equal_q, 3'h0, mode_ten_bit_q};
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 32'h00000000;
        end else if (req & !ack_q & avs_read) begin
            rdata_q <= read_mux(avs_address, sc1_view, sc2_view, compare_value_q, result_q);
        end
    end
    assign avs_readdata = rdata_q;

    // Control one register; flag bit not writable
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            channel_select_q <= acc_pkg::CH_RESET;
            complete_irq_enable_q <= 1'b0;
            continuous_enable_q <= 1'b0;
        end else if (wr_sc1) begin
            channel_select_q <= wr_channel;
            complete_irq_enable_q <= avs_writedata[acc_pkg::SC1_COMPLETE_IRQ_ENABLE];
            continuous_enable_q <= avs_writedata[acc_pkg::SC1_CONTINUOUS_ENABLE];
        end
    end

    // Control two register; active bit not writable
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            trigger_select_q <= acc_pkg::SC2_RESET[acc_pkg::SC2_TRG];
            compare_enable_q <= acc_pkg::SC2_RESET[acc_pkg::SC2_CFE];
            compare_greater_equal_q <= acc_pkg::SC2_RESET[acc_pkg::SC2_CGT];
            mode_ten_bit_q <= acc_pkg::SC2_RESET[acc_pkg::SC2_MODE10];
        end else if (wr_sc2) begin
            trigger_select_q <= avs_writedata[acc_pkg::SC2_TRG];
            compare_enable_q <= avs_writedata[acc_pkg::SC2_CFE];
            compare_greater_equal_q <= avs_writedata[acc_pkg::SC2_CGT];
            mode_ten_bit_q <= avs_writedata[acc_pkg::SC2_MODE10];
        end
    end

    // Compare value register
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            compare_value_q <= acc_pkg::CVAL_RESET;
        end else if (wr_cval) begin
            compare_value_q <= avs_writedata[9:0];
        end
    end

    // Result capture only on accepted ends
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            result_q <= 10'h000;
        end else if (accept) begin
            result_q <= mode_ten_bit_q ? sar_code : {2'b00, sar_code[7:0]};
        end
    end

    // Complete flag: set wins over clear
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            conversion_complete_flag_q <= 1'b0;
        end else if (accept) begin
            conversion_complete_flag_q <= 1'b1;
        end else if (wr_sc1 | rd_res) begin
            conversion_complete_flag_q <= 1'b0;
        end
    end
    assign complete_irq = conversion_complete_flag_q & complete_irq_enable_q;

    // Trigger history and continuous arming
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            trig_prev_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            trig_prev_q <= hw_trigger_in;
            if (wr_sc1) begin
                armed_q <= 1'b0;
            end
            if (start_now) begin
                armed_q <= 1'b1;
            end
        end
    end

    // Sequencer: idle (low power) or converting
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= acc_pkg::ST_IDLE;
            cnt_q <= 5'h00;
        end else begin
            case (state_q)
                acc_pkg::ST_IDLE: begin
                    cnt_q <= 5'h00;
                    if (start_now) begin
                        state_q <= acc_pkg::ST_CONV;
                    end
                end
                acc_pkg::ST_CONV: begin
                    cnt_q <= (cnt_q == acc_pkg::CONV_LAST) ? cnt_q : cnt_q + 5'h01;
                    if (wr_sc1) begin
                        // Abort; restart if live software channel
                        cnt_q <= 5'h00;
                        state_q <= sw_go ? acc_pkg::ST_CONV : acc_pkg::ST_IDLE;
                    end else if (conv_end) begin
                        cnt_q <= 5'h00;
                        state_q <= restart ? acc_pkg::ST_CONV : acc_pkg::ST_IDLE;
                    end else if (timeout) begin
                        state_q <= acc_pkg::ST_CONV;
                    end
                end
                default: begin
                    state_q <= acc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Core controls
    wire fresh = start_now & ((state_q == acc_pkg::ST_IDLE) | wr_sc1);
    assign sar_start = fresh | restart;
    assign sar_power = (state_q == acc_pkg::ST_CONV) | sar_start;
    assign sar_channel = channel_select_q;
    wire unused_ok = timeout;
endmodule
`default_nettype wire

/* File: testbench/acc_top_chk.sv */
/* Checker for acc_top: flag clearing, starts, power and interrupt.
   Assumes it is bound to acc_top and sees only that module's ports. */
`timescale 1ns/1ns
`default_nettype none
module acc_top_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic hw_trigger_in,
    input wire logic [9:0] sar_code,
    input wire logic sar_done,
    input wire logic sar_start,
    input wire logic sar_power,
    input wire logic [4:0] sar_channel,
    input wire logic complete_irq
);
    logic [7:0] sc1_q; // Shadow of control one
    logic [7:0] sc2_q; // Shadow of control two
    wire bus_wr = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire sc1_wr = bus_wr && avs_address == acc_pkg::REG_SC1;
    wire sc2_wr = bus_wr && avs_address == acc_pkg::REG_SC2;
    wire res_rd = avs_read && !avs_waitrequest && avs_address == acc_pkg::REG_RES;
    wire done_ok = sar_done && sar_power && !avs_write; // End with no write
    // Snoop the control fields
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sc1_q <= 8'h1f;
            sc2_q <= 8'h00;
        end else begin
            if (sc1_wr) sc1_q <= avs_writedata[7:0];
            if (sc2_wr) sc2_q <= avs_writedata[7:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_sc1_wr; sc1_wr; endsequence
    sequence s_res_rd; res_rd && !sar_done; endsequence
    property p_wr_clear; s_sc1_wr |=> !complete_irq; endproperty
    a_wr_clear: assert property (p_wr_clear) else $error("irq after ctl write");
    property p_rd_clear; s_res_rd |=> !complete_irq; endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("irq after read");
    property p_sw_start;
        s_sc1_wr ##0 (!sc2_q[6] && avs_writedata[4:0] != acc_pkg::CH_OFF) |-> sar_start;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("no start");
    property p_off;
        s_sc1_wr ##0 (avs_writedata[4:0] == acc_pkg::CH_OFF) |-> !sar_start ##1 !sar_power;
    endproperty
    a_off: assert property (p_off) else $error("off code ran");
    property p_chan; s_sc1_wr |=> sar_channel == $past(avs_writedata[4:0]); endproperty
    a_chan: assert property (p_chan) else $error("channel wrong");
    property p_single; done_ok && !sc1_q[5] && !sc2_q[6] |=> !sar_power; endproperty
    a_single: assert property (p_single) else $error("still powered");
    property p_cont; done_ok && sc1_q[5] && !sc2_q[6] |-> ##[0:2] sar_start; endproperty
    a_cont: assert property (p_cont) else $error("no restart");
    property p_irq_set; done_ok && sc1_q[6] && !sc2_q[5] |=> complete_irq; endproperty
    a_irq_set: assert property (p_irq_set) else $error("irq missing");
    property p_irq_cause; $rose(complete_irq) |-> $past(sar_done); endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq no cause");
    property p_start_pwr; sar_start |=> sar_power; endproperty
    a_start_pwr: assert property (p_start_pwr) else $error("not active");
endmodule
bind acc_top acc_top_chk u_chk (.clk, .nrst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .hw_trigger_in,
    .sar_code, .sar_done, .sar_start, .sar_power, .sar_channel, .complete_irq);
`default_nettype wire

/* File: testbench/adc_conversion_control_tb.sv */
/* Testbench for acc_top: bus tasks and conversion scenarios.
   Assumes acc_pkg, acc_top and the checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_control_tb;
    logic clk, nrst, avs_read, avs_write, hw_trigger_in, sar_done;
    logic avs_waitrequest, sar_start, sar_power, complete_irq;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [9:0] sar_code;
    logic [4:0] sar_channel;
    int n_errors, checks_done;
    // Compare table: control two, compare value, code, flag, result
    logic [7:0] t_s2 [0:4] = '{8'h21, 8'h21, 8'h31, 8'h31, 8'h30};
    logic [9:0] t_cv [0:4] = '{10'h100, 10'h100, 10'h100, 10'h100, 10'h300};
    logic [9:0] t_cd [0:4] = '{10'h200, 10'h050, 10'h100, 10'h0ff, 10'h005};
    logic [7:0] t_fl [0:4] = '{8'h00, 8'h80, 8'h80, 8'h00, 8'h80};
    logic [9:0] t_rs [0:4] = '{10'h0a5, 10'h050, 10'h100, 10'h100, 10'h000};
    always #10 clk = ~clk;
    acc_top dut (.clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .hw_trigger_in, .sar_code,
        .sar_done, .sar_start, .sar_power, .sar_channel, .complete_irq);
    // Count and report one comparison
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One bus transfer, held until waitrequest is low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // Let outputs settle before any port compare
        @(negedge clk);
    endtask
    // Read and compare masked bits
    task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] m,
        input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, rd & m, e);
    endtask
    // Core finishes a conversion with a code
    task automatic conv(input logic [9:0] c);
        repeat (3) @(posedge clk);
        sar_code <= c;
        sar_done <= 1'b1;
        @(posedge clk);
        sar_done <= 1'b0;
        sar_code <= ~c;
        @(negedge clk);
    endtask
    // Print counts and verdict
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Cut a hang short
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        test_done();
    end
    // Main sequence
    initial begin
        {clk, nrst, avs_read, avs_write, hw_trigger_in, sar_done} = 6'h0;
        {avs_address, avs_writedata, sar_code} = '0;
        avs_byteenable = 4'hf;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rchk("sc1", acc_pkg::REG_SC1, 32'hff, 32'h1f);
        rchk("sc2", acc_pkg::REG_SC2, 32'hff, 32'h00);
        $display("test reset done");
        bus(1'b1, acc_pkg::REG_SC1, 32'hc3);
        chk("chan", sar_channel, 32'h3);
        rchk("act", acc_pkg::REG_SC2, 32'h80, 32'h80);
        rchk("ro", acc_pkg::REG_SC1, 32'hff, 32'h43);
        conv(10'h2a5);
        rchk("flag", acc_pkg::REG_SC1, 32'h80, 32'h80);
        chk("irq", complete_irq, 32'h1);
        rchk("idle", acc_pkg::REG_SC2, 32'h80, 32'h0);
        chk("lowpwr", sar_power, 32'h0);
        rchk("res", acc_pkg::REG_RES, 32'h3ff, 32'h0a5);
        chk("irqclr", complete_irq, 32'h0);
        $display("test single done");
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, acc_pkg::REG_SC2, 32'(t_s2[i]));
            bus(1'b1, acc_pkg::REG_CVAL, 32'(t_cv[i]));
            bus(1'b1, acc_pkg::REG_SC1, 32'h00);
            conv(t_cd[i]);
            rchk("cmp", acc_pkg::REG_SC1, 32'h80, 32'(t_fl[i]));
            if (t_s2[i][0]) rchk("keep", acc_pkg::REG_RES, 32'h3ff, 32'(t_rs[i]));
        end
        $display("test compare done");
        bus(1'b1, acc_pkg::REG_SC2, 32'h00);
        bus(1'b1, acc_pkg::REG_SC1, 32'h61);
        conv(10'h001);
        conv(10'h002);
        chk("cont", sar_power, 32'h1);
        rchk("cflag", acc_pkg::REG_SC1, 32'h80, 32'h80);
        bus(1'b1, acc_pkg::REG_SC1, 32'h7f);
        rchk("wclr", acc_pkg::REG_SC1, 32'h80, 32'h0);
        chk("off", sar_power, 32'h0);
        $display("test continuous done");
        bus(1'b1, acc_pkg::REG_SC2, 32'h40);
        bus(1'b1, acc_pkg::REG_SC1, 32'h02);
        rchk("wait", acc_pkg::REG_SC2, 32'h80, 32'h0);
        @(posedge clk);
        hw_trigger_in <= 1'b1;
        repeat (4) @(posedge clk);
        rchk("hwact", acc_pkg::REG_SC2, 32'h80, 32'h80);
        conv(10'h3ff);
        repeat (4) @(posedge clk);
        rchk("once", acc_pkg::REG_SC2, 32'h80, 32'h0);
        hw_trigger_in <= 1'b0;
        @(posedge clk);
        hw_trigger_in <= 1'b1;
        repeat (4) @(posedge clk);
        rchk("again", acc_pkg::REG_SC2, 32'h80, 32'h80);
        conv(10'h155);
        $display("test hardware done");
        test_done();
    end
endmodule
`default_nettype wire
